// ==== design/css_pkg.sv ====
// package: codes, widths and carrier struct for the command source selector
package css_pkg;
   // command value widths
   localparam int FREQ_W = 16;
   localparam int RUN_W = 4;
   // serial link source code
   localparam logic [3:0] SL_LOCAL = 4'h0;
   localparam logic [3:0] SL_F1_RL = 4'h1;
   localparam logic [3:0] SL_FL_R1 = 4'h2;
   localparam logic [3:0] SL_F1_R1 = 4'h3;
   localparam logic [3:0] SL_F2_RL = 4'h4;
   localparam logic [3:0] SL_F2_R1 = 4'h5;
   localparam logic [3:0] SL_FL_R2 = 4'h6;
   localparam logic [3:0] SL_F1_R2 = 4'h7;
   localparam logic [3:0] SL_F2_R2 = 4'h8;
   // fieldbus source code
   localparam logic [1:0] FB_NONE = 2'h0;
   localparam logic [1:0] FB_FREQ = 2'h1;
   localparam logic [1:0] FB_RUN = 2'h2;
   localparam logic [1:0] FB_BOTH = 2'h3;
   // resolved origin of one command
   typedef enum logic [1:0] {
      CSS_SRC_LOCAL,
      CSS_SRC_PORT1,
      CSS_SRC_PORT2,
      CSS_SRC_FBUS
   } css_src_e;
   // one command source: frequency and run words
   typedef struct packed {
      logic [FREQ_W-1:0] freq;
      logic [RUN_W-1:0] run;
   } css_cmd_s;
   // reset values
   localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;
   localparam logic [RUN_W-1:0] RUN_RST = 4'h0;
endpackage

// ==== design/css_decode.sv ====
// module: decodes the two source codes and link enable into origins
`timescale 1ns/1ps
module css_decode (
   input wire logic [3:0] sl_code,
   input wire logic [1:0] fb_code,
   input wire logic link_en,
   output css_pkg::css_src_e freq_src,
   output css_pkg::css_src_e run_src
);
   // serial-link-only choice before the fieldbus overlay
   css_pkg::css_src_e sl_freq;
   css_pkg::css_src_e sl_run;

   ////////////////////////////////////////////////////////////////////////
   // serial link table
   always_comb begin
      sl_freq = css_pkg::CSS_SRC_LOCAL;
      sl_run = css_pkg::CSS_SRC_LOCAL;
      case (sl_code)
         css_pkg::SL_LOCAL: begin
            sl_freq = css_pkg::CSS_SRC_LOCAL;
            sl_run = css_pkg::CSS_SRC_LOCAL;
         end
         css_pkg::SL_F1_RL: begin
            sl_freq = css_pkg::CSS_SRC_PORT1;
         end
         css_pkg::SL_FL_R1: begin
            sl_run = css_pkg::CSS_SRC_PORT1;
         end
         css_pkg::SL_F1_R1: begin
            sl_freq = css_pkg::CSS_SRC_PORT1;
            sl_run = css_pkg::CSS_SRC_PORT1;
         end
         css_pkg::SL_F2_RL: begin
            sl_freq = css_pkg::CSS_SRC_PORT2;
         end
         css_pkg::SL_F2_R1: begin
            sl_freq = css_pkg::CSS_SRC_PORT2;
            sl_run = css_pkg::CSS_SRC_PORT1;
         end
         css_pkg::SL_FL_R2: begin
            sl_run = css_pkg::CSS_SRC_PORT2;
         end
         css_pkg::SL_F1_R2: begin
            sl_freq = css_pkg::CSS_SRC_PORT1;
            sl_run = css_pkg::CSS_SRC_PORT2;
         end
         css_pkg::SL_F2_R2: begin
            sl_freq = css_pkg::CSS_SRC_PORT2;
            sl_run = css_pkg::CSS_SRC_PORT2;
         end
         // codes above 8 are undefined: stay local, the safe side
         default: begin
            sl_freq = css_pkg::CSS_SRC_LOCAL;
            sl_run = css_pkg::CSS_SRC_LOCAL;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // fieldbus overlay and link enable gate
   always_comb begin
      freq_src = sl_freq;
      run_src = sl_run;
      if (fb_code == css_pkg::FB_FREQ || fb_code == css_pkg::FB_BOTH) begin
         freq_src = css_pkg::CSS_SRC_FBUS;
      end
      if (fb_code == css_pkg::FB_RUN || fb_code == css_pkg::FB_BOTH) begin
         run_src = css_pkg::CSS_SRC_FBUS;
      end
      // link disabled forces both commands local
      if (!link_en) begin
         freq_src = css_pkg::CSS_SRC_LOCAL;
         run_src = css_pkg::CSS_SRC_LOCAL;
      end
   end
endmodule

// ==== design/css_top.sv ====
// module: command source selector, top level with registered outputs
`timescale 1ns/1ps
module css_top #(
   parameter int FREQ_W = css_pkg::FREQ_W,
   parameter int RUN_W = css_pkg::RUN_W
) (
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic [3:0] SERIAL_LINK_SOURCE_CODE,
   input wire logic [1:0] FIELDBUS_SOURCE_CODE,
   input wire logic LINK_ENABLE_ASSIGNED,
   input wire logic LINK_ENABLE_INPUT,
   input wire logic LOCAL_FREQ_SOURCE_SEL_ALT,
   input wire logic MULTI_FREQ_ACTIVE,
   input wire logic [FREQ_W-1:0] LOCAL_FREQ_A,
   input wire logic [FREQ_W-1:0] LOCAL_FREQ_B,
   input wire logic [FREQ_W-1:0] MULTI_FREQ,
   input wire logic LOCAL_RUN_SOURCE_SEL,
   input wire logic [RUN_W-1:0] KEYPAD_RUN,
   input wire logic [RUN_W-1:0] TERMINAL_RUN,
   input wire logic [FREQ_W-1:0] PORT1_FREQ,
   input wire logic [RUN_W-1:0] PORT1_RUN,
   input wire logic [FREQ_W-1:0] PORT2_FREQ,
   input wire logic [RUN_W-1:0] PORT2_RUN,
   input wire logic [FREQ_W-1:0] FBUS_FREQ,
   input wire logic [RUN_W-1:0] FBUS_RUN,
   output logic [FREQ_W-1:0] FREQ_CMD,
   output logic [RUN_W-1:0] RUN_CMD,
   output css_pkg::css_src_e FREQ_SRC,
   output css_pkg::css_src_e RUN_SRC
);
   // effective link enable after the assignment check
   logic link_en;
   // combinational origins from the decoder
   css_pkg::css_src_e dec_freq_src;
   css_pkg::css_src_e dec_run_src;
   // local command after its own selectors
   logic [FREQ_W-1:0] local_freq;
   logic [RUN_W-1:0] local_run;
   // next values of the output flops
   logic [FREQ_W-1:0] next_freq_cmd;
   logic [RUN_W-1:0] next_run_cmd;
   css_pkg::css_src_e next_freq_src;
   css_pkg::css_src_e next_run_src;

   ////////////////////////////////////////////////////////////////////////
   // link enable: no terminal assigned behaves as always on
   assign link_en = !LINK_ENABLE_ASSIGNED || LINK_ENABLE_INPUT;

   // source decoding lives in its own module
   css_decode u_decode (
      .sl_code(SERIAL_LINK_SOURCE_CODE),
      .fb_code(FIELDBUS_SOURCE_CODE),
      .link_en(link_en),
      .freq_src(dec_freq_src),
      .run_src(dec_run_src)
   );

   ////////////////////////////////////////////////////////////////////////
   // local command sources
   always_comb begin
      // multi-frequency overrides the set frequency selector
      if (MULTI_FREQ_ACTIVE) begin
         local_freq = MULTI_FREQ;
      end else if (LOCAL_FREQ_SOURCE_SEL_ALT) begin
         local_freq = LOCAL_FREQ_B;
      end else begin
         local_freq = LOCAL_FREQ_A;
      end
      // run selector: high takes the terminals, low the keypad
      local_run = LOCAL_RUN_SOURCE_SEL ? TERMINAL_RUN : KEYPAD_RUN;
   end

   ////////////////////////////////////////////////////////////////////////
   // output muxes; no history kept, so a switch is clean at once
   always_comb begin
      next_freq_src = dec_freq_src;
      next_run_src = dec_run_src;
      case (dec_freq_src)
         css_pkg::CSS_SRC_LOCAL: next_freq_cmd = local_freq;
         css_pkg::CSS_SRC_PORT1: next_freq_cmd = PORT1_FREQ;
         css_pkg::CSS_SRC_PORT2: next_freq_cmd = PORT2_FREQ;
         css_pkg::CSS_SRC_FBUS: next_freq_cmd = FBUS_FREQ;
         default: next_freq_cmd = local_freq;
      endcase
      case (dec_run_src)
         css_pkg::CSS_SRC_LOCAL: next_run_cmd = local_run;
         css_pkg::CSS_SRC_PORT1: next_run_cmd = PORT1_RUN;
         css_pkg::CSS_SRC_PORT2: next_run_cmd = PORT2_RUN;
         css_pkg::CSS_SRC_FBUS: next_run_cmd = FBUS_RUN;
         default: next_run_cmd = local_run;
      endcase
   end

   // output registers; reset holds run off and frequency zero
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         FREQ_CMD <= FREQ_W'(css_pkg::FREQ_RST);
         RUN_CMD <= RUN_W'(css_pkg::RUN_RST);
         FREQ_SRC <= css_pkg::CSS_SRC_LOCAL;
         RUN_SRC <= css_pkg::CSS_SRC_LOCAL;
      end else begin
         FREQ_CMD <= next_freq_cmd;
         RUN_CMD <= next_run_cmd;
         FREQ_SRC <= next_freq_src;
         RUN_SRC <= next_run_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_link_off;
      LINK_ENABLE_ASSIGNED && !LINK_ENABLE_INPUT;
   endsequence
   sequence s_both_local;
      FREQ_SRC == css_pkg::CSS_SRC_LOCAL && RUN_SRC == css_pkg::CSS_SRC_LOCAL;
   endsequence

   a_link_off_local: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      s_link_off |=> s_both_local)
      else $error("link disabled but a remote source chosen");
   a_fb_freq_claim: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      link_en && FIELDBUS_SOURCE_CODE[0]
      |=> FREQ_SRC == css_pkg::CSS_SRC_FBUS && FREQ_CMD == $past(FBUS_FREQ))
      else $error("fieldbus frequency claim not honoured");
   a_fb_run_claim: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      link_en && FIELDBUS_SOURCE_CODE[1]
      |=> RUN_SRC == css_pkg::CSS_SRC_FBUS && RUN_CMD == $past(FBUS_RUN))
      else $error("fieldbus run claim not honoured");
   a_code3_port1: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      link_en && FIELDBUS_SOURCE_CODE == css_pkg::FB_NONE
      && SERIAL_LINK_SOURCE_CODE == css_pkg::SL_F1_R1
      |=> FREQ_CMD == $past(PORT1_FREQ) && RUN_CMD == $past(PORT1_RUN))
      else $error("serial code 3 not both from port 1");
   a_code5_mix: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      link_en && FIELDBUS_SOURCE_CODE == css_pkg::FB_NONE
      && SERIAL_LINK_SOURCE_CODE == css_pkg::SL_F2_R1
      |=> FREQ_SRC == css_pkg::CSS_SRC_PORT2
      && RUN_SRC == css_pkg::CSS_SRC_PORT1)
      else $error("serial code 5 routing wrong");
   a_unclaimed_follow: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      link_en && FIELDBUS_SOURCE_CODE == css_pkg::FB_FREQ
      && SERIAL_LINK_SOURCE_CODE == css_pkg::SL_FL_R2
      |=> RUN_SRC == css_pkg::CSS_SRC_PORT2)
      else $error("unclaimed run did not follow serial code");
   a_unassigned_on: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      !LINK_ENABLE_ASSIGNED && FIELDBUS_SOURCE_CODE == css_pkg::FB_BOTH
      |=> FREQ_SRC == css_pkg::CSS_SRC_FBUS)
      else $error("unassigned link enable did not act as on");
   a_local_freq: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      s_link_off ##0 MULTI_FREQ_ACTIVE |=> FREQ_CMD == $past(MULTI_FREQ))
      else $error("multi-frequency not passed when local");
   a_switch_fresh: assert property (
      @(posedge CLK_SYS) disable iff (SRST)
      $changed(dec_run_src) && dec_run_src == css_pkg::CSS_SRC_PORT2
      |=> RUN_CMD == $past(PORT2_RUN))
      else $error("new source value not passed on switch");
endmodule

// ==== sim/css_host_model.sv ====
// remote host model: serial link ports 1 and 2 and the fieldbus option
`timescale 1ns/1ps
module css_host_model (
   input wire logic clk,
   input wire logic slow,
   output css_pkg::css_cmd_s port1,
   output css_pkg::css_cmd_s port2,
   output css_pkg::css_cmd_s fbus
);
   logic [1:0] pace; // slow hosts refresh only every fourth cycle

   ////////////////////////////////////////////////////////////////////////
   // known words from time zero, so no unknown reaches the selector
   initial begin
      port1 = '0;
      port2 = '0;
      fbus = '0;
      pace = 2'h0;
   end

   // hosts change just after the edge; a prompt host sends a new word
   // every cycle, so a stale source value passes for a fresh one only when $urandom repeats it
   always @(posedge clk) begin
      pace <= pace + 2'h1;
      if (!slow || pace == 2'h0) begin
         port1 <= css_pkg::css_cmd_s'(20'($urandom));
         port2 <= css_pkg::css_cmd_s'(20'($urandom));
         fbus <= css_pkg::css_cmd_s'(20'($urandom));
      end
   end
endmodule

// ==== sim/tb_top.sv ====
// testbench: drives the selector, compares against a behavioural model
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      check_count++; \
      if ((got) !== (ex)) begin \
         bad_count++; \
         $display("Error %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb_top;
   logic clk_sys, srst, le_asg, le_in, alt, mact, run_sel, slow;
   logic [3:0] sl_code;
   logic [1:0] fb_code;
   logic [15:0] fa, fb, fm;
   logic [3:0] key_run, term_run, run_cmd;
   logic [15:0] freq_cmd;
   css_pkg::css_src_e fsrc, rsrc;
   css_pkg::css_cmd_s p1, p2, pf;
   int bad_count, check_count, cyc;

   ////////////////////////////////////////////////////////////////////////
   css_top css_top_inst (.CLK_SYS(clk_sys), .SRST(srst),
      .SERIAL_LINK_SOURCE_CODE(sl_code), .FIELDBUS_SOURCE_CODE(fb_code),
      .LINK_ENABLE_ASSIGNED(le_asg), .LINK_ENABLE_INPUT(le_in),
      .LOCAL_FREQ_SOURCE_SEL_ALT(alt), .MULTI_FREQ_ACTIVE(mact),
      .LOCAL_FREQ_A(fa), .LOCAL_FREQ_B(fb), .MULTI_FREQ(fm),
      .LOCAL_RUN_SOURCE_SEL(run_sel), .KEYPAD_RUN(key_run),
      .TERMINAL_RUN(term_run), .PORT1_FREQ(p1.freq), .PORT1_RUN(p1.run),
      .PORT2_FREQ(p2.freq), .PORT2_RUN(p2.run), .FBUS_FREQ(pf.freq),
      .FBUS_RUN(pf.run), .FREQ_CMD(freq_cmd), .RUN_CMD(run_cmd),
      .FREQ_SRC(fsrc), .RUN_SRC(rsrc));
   css_host_model css_host_model_inst (.clk(clk_sys), .slow(slow),
      .port1(p1), .port2(p2), .fbus(pf));

   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run, the one exit point
   task automatic results();
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one cycle of stimulus: codes given, local sources random
   task automatic drive(input logic [3:0] sl, input logic [1:0] fbc,
                        input logic [1:0] le);
      @(posedge clk_sys);
      sl_code <= sl;
      fb_code <= fbc;
      {le_asg, le_in} <= le;
      {alt, mact, run_sel} <= 3'($urandom);
      fa <= 16'($urandom);
      fb <= 16'($urandom);
      fm <= 16'($urandom);
      {key_run, term_run} <= 8'($urandom);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock at 200 MHz
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // watchdog: a hung run counts as a mismatch
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 20000) begin
         bad_count++;
         results();
      end
   end

   // reference model: inputs seen at edge n must show just after edge n
   always @(posedge clk_sys) begin : ref_model
      int fs, rs, sl;
      logic le, rst;
      logic [15:0] ef;
      logic [3:0] er;
      rst = srst;
      sl = int'(sl_code);
      le = !le_asg || le_in; // unassigned terminal acts as on
      fs = 0;
      rs = 0;
      if (le && fb_code[0]) fs = 3;
      else if (le && sl inside {1, 3, 7}) fs = 1;
      else if (le && sl inside {4, 5, 8}) fs = 2;
      if (le && fb_code[1]) rs = 3;
      else if (le && sl inside {2, 3, 5}) rs = 1;
      else if (le && sl inside {6, 7, 8}) rs = 2;
      case (fs)
         0: ef = mact ? fm : (alt ? fb : fa);
         1: ef = p1.freq;
         2: ef = p2.freq;
         default: ef = pf.freq;
      endcase
      case (rs)
         0: er = run_sel ? term_run : key_run;
         1: er = p1.run;
         2: er = p2.run;
         default: er = pf.run;
      endcase
      if (rst) begin
         ef = css_pkg::FREQ_RST;
         er = css_pkg::RUN_RST;
         fs = 0;
         rs = 0;
      end
      #1;
      `CHK("freq_src", css_pkg::css_src_e'(fs), fsrc)
      `CHK("run_src", css_pkg::css_src_e'(rs), rsrc)
      `CHK("freq_cmd", ef, freq_cmd)
      `CHK("run_cmd", er, run_cmd)
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence: reset, every code combination, random, mid-run reset
   initial begin
      void'($urandom(99707));
      {srst, slow} = 2'h2;
      {sl_code, fb_code, le_asg, le_in, alt, mact, run_sel} = '0;
      {fa, fb, fm, key_run, term_run} = '0;
      {bad_count, check_count, cyc} = '0;
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      // all serial codes incl. undefined, all fieldbus codes, all enables
      for (int i = 0; i < 256; i++) begin
         drive(4'(i >> 4), 2'(i >> 2), 2'(i));
      end
      for (int i = 0; i < 3000; i++) begin
         if (i == 1500) slow <= 1'b1; // hosts now refresh slowly
         if (i == 2000) srst <= 1'b1; // second reset in mid-run
         if (i == 2003) srst <= 1'b0;
         drive(4'($urandom_range(0, 9)), 2'($urandom), 2'($urandom));
      end
      repeat (2) @(posedge clk_sys);
      results();
   end
endmodule
